// File: src/dsq_params.svh
`ifndef DSQ_PARAMS_SVH
`define DSQ_PARAMS_SVH

// Register word indices (byte address = index * 4)
`define DSQ_IDX_ERR     6'h04
`define DSQ_IDX_CTL     6'h05
`define DSQ_IDX_VAL     6'h06
`define DSQ_IDX_CNT     6'h07
`define DSQ_IDX_START   6'h0C
`define DSQ_IDX_BRANCH  6'h0D
`define DSQ_IDX_REPEAT  6'h0E
`define DSQ_IDX_SECTOR  6'h0F
`define DSQ_IDX_MARK    6'h10
`define DSQ_IDX_CMD     6'h11
`define DSQ_IDX_STATUS  6'h12
`define DSQ_IDX_IDWR    6'h13
`define DSQ_IDX_IDRD    6'h14

// Instruction word layout
`define DSQ_INS_ERR_LSB 24
`define DSQ_INS_CTL_LSB 16
`define DSQ_INS_VAL_LSB 8
`define DSQ_INS_CNT_LSB 0

// Control byte fields
`define DSQ_CTL_VAL_SEL 7
`define DSQ_CTL_CNT_SEL 6
`define DSQ_CTL_WG      5
`define DSQ_CTL_RG      4
`define DSQ_CTL_MARK    3
`define DSQ_CTL_CMP     2
`define DSQ_CTL_BRANCH  1
`define DSQ_CTL_REPEAT  0

// Value select fields
`define DSQ_VAL_BUF     7
`define DSQ_VAL_VERIFY  6
`define DSQ_VAL_LAST    5
`define DSQ_VAL_ID      4
`define DSQ_VAL_CHK     3

// Count wait fields
`define DSQ_CNT_INDEX   5
`define DSQ_CNT_SECTOR  4
`define DSQ_CNT_STOP    0

// Error control byte and command register
`define DSQ_ERR_DAC     1
`define DSQ_CMD_RUN     0
`define DSQ_CMD_KILL    1

// Reset values and bit timer divider
`define DSQ_RST_BYTE    8'h00
`define DSQ_RST_ADDR    5'h00
`define DSQ_BIT_DIV     4

`endif

// File: src/dsq_pkg.sv
package dsq_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FETCH, SEQ_WAIT, SEQ_EXEC} seq_state_t;

  typedef struct packed {
    seq_state_t  st;
    logic [4:0]  pc;
    logic [4:0]  ptr;
    logic [4:0]  branch;
    logic [4:0]  repeat_tgt;
    logic [7:0]  sector;
    logic [7:0]  mark;
    logic [7:0]  id_wr;
    logic [7:0]  id_rd;
    logic [7:0]  bytes;
    logic [27:0] ins;
    logic [7:0]  tx;
    logic [31:0] rdata;
    logic        ack;
    logic [2:0]  idx_s;
    logic [2:0]  sm_s;
    logic [2:0]  rty_s;
    logic        rty_hold;
    logic        xfer_d;
    logic        miscmp;
    logic        stopped;
  } seq_regs_t;

  typedef struct packed {
    logic [7:0] div;
    logic [2:0] bit_num;
  } bit_regs_t;
endpackage

// File: src/ctl_store.sv
`timescale 1ns/100ps
module ctl_store #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // Clock
  input  wire logic          ref_clk_i,
  // Write port, one lane per byte field
  input  wire logic [3:0]    wr_lane_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [7:0]    wr_data_i,
  // Read ports
  input  wire logic [AW-1:0] rd_a_addr_i,
  output logic      [27:0]   rd_a_data_o,
  input  wire logic [AW-1:0] rd_b_addr_i,
  output logic      [27:0]   rd_b_data_o
);
  // Contents survive reset on purpose, so no reset here
  logic [27:0] mem [DEPTH];

  always_ff @(posedge ref_clk_i) begin
    if (wr_lane_i[3]) mem[wr_addr_i][27:24] <= wr_data_i[3:0];
    if (wr_lane_i[2]) mem[wr_addr_i][23:16] <= wr_data_i;
    if (wr_lane_i[1]) mem[wr_addr_i][15:8]  <= wr_data_i;
    if (wr_lane_i[0]) mem[wr_addr_i][7:0]   <= wr_data_i;
  end

  assign rd_a_data_o = mem[rd_a_addr_i];
  assign rd_b_data_o = mem[rd_b_addr_i];
endmodule // ctl_store

// File: src/bit_timer.sv
`include "dsq_params.svh"
`timescale 1ns/100ps
module bit_timer #(
  parameter int BIT_DIV = `DSQ_BIT_DIV
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // Control
  input  wire logic       restart_i,
  // Timing
  output logic            bit_tick_o,
  output logic            byte_tick_o,
  output logic [2:0]      bit_num_o
);
  import dsq_pkg::*;

  bit_regs_t r_r;
  bit_regs_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    bit_tick_o = (r_r.div == 8'(BIT_DIV - 1));
    byte_tick_o = bit_tick_o && (r_r.bit_num == 3'h7);
    if (restart_i) begin
      r_nxt = '0;
    end else if (bit_tick_o) begin
      r_nxt.div = 8'h00;
      r_nxt.bit_num = r_r.bit_num + 3'h1;
    end else begin
      r_nxt.div = r_r.div + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) r_r <= '0;
    else          r_r <= r_nxt;
  end

  assign bit_num_o = r_r.bit_num;
endmodule // bit_timer

// File: src/disk_seq.sv
// Register access over Avalon-MM was decided locally.
`include "dsq_params.svh"
`timescale 1ns/100ps
module disk_seq #(
  parameter int BIT_DIV = `DSQ_BIT_DIV
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Drive pins
  input  wire logic        index_i,
  input  wire logic        sector_mark_i,
  input  wire logic        retry_i,
  output logic             write_gate_o,
  output logic             read_gate_o,
  output logic             mark_enable_output_o,
  output logic             serial_write_data_o,
  // Serial channel bytes
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        checksum_bit_i,
  output logic             compare_enable_o,
  output logic             checksum_field_o,
  output logic             ecc_select_o,
  output logic             crc_select_o,
  output logic             last_segment_o,
  // Data buffer
  input  wire logic [7:0]  buf_rd_data_i,
  output logic             buf_rd_o,
  output logic             buf_wr_o,
  output logic      [7:0]  buf_wr_data_o
);
  import dsq_pkg::*;

  seq_regs_t r_r;
  seq_regs_t r_nxt;

  logic [27:0] store_ptr_q;
  logic [27:0] store_pc_q;
  logic [3:0]  wr_lane;
  logic        bit_tick;
  logic        byte_tick;
  logic [2:0]  bit_num;
  logic        bus_req;
  logic        bus_wr;
  logic [5:0]  idx;
  logic [7:0]  ctl;
  logic [7:0]  val;
  logic [7:0]  cnt;
  logic        exec;
  logic        sel_mode;
  logic        xfer;
  logic        idx_seen;
  logic        sm_seen;
  logic        ins_done;
  logic        wait_go;
  logic        rd_dir;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Byte that the current instruction puts on the line
  function automatic logic [7:0] src_byte(input logic [27:0] w, input logic [7:0] bd,
                                          input logic [7:0] idw);
    logic [7:0] v;
    v = w[`DSQ_INS_VAL_LSB +: 8];
    if (!w[`DSQ_INS_CTL_LSB + `DSQ_CTL_VAL_SEL]) src_byte = v;
    else if (v[`DSQ_VAL_BUF]) src_byte = bd;
    else if (v[`DSQ_VAL_ID]) src_byte = idw;
    else src_byte = 8'h00;
  endfunction

  function automatic logic [4:0] next_addr(input logic [7:0] c, input logic [4:0] pc,
                                           input logic [4:0] br, input logic [4:0] rp,
                                           input logic [7:0] sec);
    if (c[`DSQ_CTL_BRANCH]) next_addr = br;
    else if (c[`DSQ_CTL_REPEAT] && sec != 8'h00) next_addr = rp;
    else next_addr = pc + 5'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  ctl_store #(.DEPTH(32), .AW(5)) u_store (
    .ref_clk_i   (ref_clk_i),
    .wr_lane_i   (wr_lane),
    .wr_addr_i   (r_r.ptr),
    .wr_data_i   (avs_writedata_i[7:0]),
    .rd_a_addr_i (r_r.ptr),
    .rd_a_data_o (store_ptr_q),
    .rd_b_addr_i (r_r.pc),
    .rd_b_data_o (store_pc_q)
  );

  bit_timer #(.BIT_DIV(BIT_DIV)) u_timer (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .restart_i   (r_r.st != SEQ_EXEC),
    .bit_tick_o  (bit_tick),
    .byte_tick_o (byte_tick),
    .bit_num_o   (bit_num)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign bus_req = avs_read_i || avs_write_i;
  // Write lands at the edge where waitrequest is seen low
  assign bus_wr = avs_write_i && r_r.ack;
  assign idx = avs_address_i[7:2];
  assign avs_waitrequest_o = bus_req && !r_r.ack;
  assign avs_readdata_o = r_r.rdata;

  // Window writes go straight into the store at the pointer
  always_comb begin
    wr_lane = 4'h0;
    if (bus_wr) begin
      wr_lane[3] = (idx == `DSQ_IDX_ERR);
      wr_lane[2] = (idx == `DSQ_IDX_CTL);
      wr_lane[1] = (idx == `DSQ_IDX_VAL);
      wr_lane[0] = (idx == `DSQ_IDX_CNT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode

  assign ctl = r_r.ins[`DSQ_INS_CTL_LSB +: 8];
  assign val = r_r.ins[`DSQ_INS_VAL_LSB +: 8];
  assign cnt = r_r.ins[`DSQ_INS_CNT_LSB +: 8];
  assign exec = (r_r.st == SEQ_EXEC);
  assign sel_mode = ctl[`DSQ_CTL_VAL_SEL];
  assign xfer = exec && sel_mode && (val[`DSQ_VAL_BUF] || val[`DSQ_VAL_VERIFY]);
  assign rd_dir = !ctl[`DSQ_CTL_WG];
  assign idx_seen = r_r.idx_s[1] && !r_r.idx_s[2];
  assign sm_seen = r_r.sm_s[1] && !r_r.sm_s[2];
  assign ins_done = exec && byte_tick && (r_r.bytes == 8'h00);
  assign wait_go = (cnt[`DSQ_CNT_INDEX] && idx_seen) || (cnt[`DSQ_CNT_SECTOR] && sm_seen)
                 || !(cnt[`DSQ_CNT_INDEX] || cnt[`DSQ_CNT_SECTOR]);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    r_nxt = r_r;
    r_nxt.idx_s = {r_r.idx_s[1:0], index_i};
    r_nxt.sm_s = {r_r.sm_s[1:0], sector_mark_i};
    r_nxt.rty_s = {r_r.rty_s[1:0], retry_i};
    // Held over the fetch gap, so a chained data field counts once
    r_nxt.xfer_d = xfer || (r_r.st == SEQ_FETCH && r_r.xfer_d);
    r_nxt.ack = bus_req && !r_r.ack;

    // Register reads: data stand in the cycle waitrequest drops
    if (avs_read_i && !r_r.ack) begin
      unique case (idx)
        `DSQ_IDX_ERR:    r_nxt.rdata = {28'h0, store_ptr_q[27:24]};
        `DSQ_IDX_CTL:    r_nxt.rdata = {24'h0, store_ptr_q[23:16]};
        `DSQ_IDX_VAL:    r_nxt.rdata = {24'h0, store_ptr_q[15:8]};
        `DSQ_IDX_CNT:    r_nxt.rdata = {24'h0, store_ptr_q[7:0]};
        `DSQ_IDX_START:  r_nxt.rdata = {27'h0, r_r.ptr};
        `DSQ_IDX_BRANCH: r_nxt.rdata = {27'h0, r_r.branch};
        `DSQ_IDX_REPEAT: r_nxt.rdata = {27'h0, r_r.repeat_tgt};
        `DSQ_IDX_SECTOR: r_nxt.rdata = {24'h0, r_r.sector};
        `DSQ_IDX_MARK:   r_nxt.rdata = {24'h0, r_r.mark};
        `DSQ_IDX_STATUS: r_nxt.rdata = {21'h0, r_r.st, r_r.rty_hold, r_r.stopped,
                                        r_r.miscmp, 1'b0, r_r.pc};
        `DSQ_IDX_IDWR:   r_nxt.rdata = {24'h0, r_r.id_wr};
        `DSQ_IDX_IDRD:   r_nxt.rdata = {24'h0, r_r.id_rd};
        default:         r_nxt.rdata = 32'h0000_0000;
      endcase
    end

    if (bus_wr) begin
      unique case (idx)
        `DSQ_IDX_ERR, `DSQ_IDX_CTL, `DSQ_IDX_VAL, `DSQ_IDX_CNT:
          r_nxt.ptr = r_r.ptr + 5'h01;
        `DSQ_IDX_START:  r_nxt.ptr = avs_writedata_i[4:0];
        `DSQ_IDX_BRANCH: r_nxt.branch = avs_writedata_i[4:0];
        `DSQ_IDX_REPEAT: r_nxt.repeat_tgt = avs_writedata_i[4:0];
        `DSQ_IDX_SECTOR: r_nxt.sector = avs_writedata_i[7:0];
        `DSQ_IDX_MARK:   r_nxt.mark = avs_writedata_i[7:0];
        `DSQ_IDX_IDWR:   r_nxt.id_wr = avs_writedata_i[7:0];
        `DSQ_IDX_STATUS: r_nxt.miscmp = 1'b0;
        default: ;
      endcase
    end

    // Retry drops read gate until the next byte boundary
    if (r_r.rty_s[1]) r_nxt.rty_hold = 1'b1;
    else if (byte_tick || !exec) r_nxt.rty_hold = 1'b0;

    // Leading edge of a data field move
    if (xfer && !r_r.xfer_d) begin
      if (r_r.sector != 8'h00) r_nxt.sector = r_r.sector - 8'h01;
      r_nxt.id_wr = r_r.id_wr + 8'h01;
    end

    if (exec && bit_tick) r_nxt.tx = {r_r.tx[6:0], 1'b0};

    if (exec && byte_tick && ctl[`DSQ_CTL_CMP]) begin
      if (rx_byte_i != r_r.tx) r_nxt.miscmp = 1'b1;
    end
    if (exec && byte_tick && sel_mode && val[`DSQ_VAL_ID] && rd_dir) begin
      r_nxt.id_rd = rx_byte_i;
    end

    unique case (r_r.st)
      SEQ_IDLE: begin
        if (bus_wr && idx == `DSQ_IDX_CMD && avs_writedata_i[`DSQ_CMD_RUN]) begin
          r_nxt.pc = r_r.ptr;
          r_nxt.stopped = 1'b0;
          r_nxt.st = SEQ_FETCH;
        end
      end
      SEQ_FETCH: begin
        r_nxt.ins = store_pc_q;
        r_nxt.bytes = store_pc_q[`DSQ_INS_CNT_LSB +: 8];
        r_nxt.tx = src_byte(store_pc_q, buf_rd_data_i, r_r.id_wr);
        if (store_pc_q[`DSQ_INS_CTL_LSB + `DSQ_CTL_CNT_SEL]) r_nxt.st = SEQ_WAIT;
        else r_nxt.st = SEQ_EXEC;
      end
      SEQ_WAIT: begin
        if (cnt[`DSQ_CNT_STOP]) begin
          r_nxt.stopped = 1'b1;
          r_nxt.st = SEQ_IDLE;
        end else if (wait_go) begin
          r_nxt.pc = next_addr(ctl, r_r.pc, r_r.branch, r_r.repeat_tgt, r_r.sector);
          r_nxt.st = SEQ_FETCH;
        end
      end
      SEQ_EXEC: begin
        if (byte_tick) begin
          r_nxt.bytes = r_r.bytes - 8'h01;
          r_nxt.tx = src_byte(r_r.ins, buf_rd_data_i, r_r.id_wr);
        end
        if (ins_done) begin
          r_nxt.pc = next_addr(ctl, r_r.pc, r_r.branch, r_r.repeat_tgt, r_r.sector);
          r_nxt.st = SEQ_FETCH;
        end
      end
    endcase

    // Kill wins over everything the sequencer was doing
    if (bus_wr && idx == `DSQ_IDX_CMD && avs_writedata_i[`DSQ_CMD_KILL]) begin
      r_nxt.st = SEQ_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_r <= '0;
      r_r.st <= SEQ_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all low outside an executing instruction except ecc_select_o, crc_select_o and buf_wr_data_o

  assign write_gate_o = exec && ctl[`DSQ_CTL_WG];
  assign read_gate_o = exec && ctl[`DSQ_CTL_RG] && !r_r.rty_hold;
  // Pattern bit 0 maps to the first serial bit of the byte
  assign mark_enable_output_o = exec && ctl[`DSQ_CTL_MARK] && r_r.mark[bit_num];
  assign compare_enable_o = exec && ctl[`DSQ_CTL_CMP];
  assign checksum_field_o = exec && sel_mode && val[`DSQ_VAL_CHK];
  assign ecc_select_o = r_r.ins[`DSQ_INS_ERR_LSB + `DSQ_ERR_DAC];
  assign crc_select_o = !ecc_select_o;
  assign last_segment_o = exec && sel_mode && val[`DSQ_VAL_LAST];
  assign serial_write_data_o = write_gate_o &&
                               (checksum_field_o ? checksum_bit_i : r_r.tx[7]);
  assign buf_wr_o = exec && byte_tick && sel_mode && val[`DSQ_VAL_BUF] && rd_dir
                    && !ctl[`DSQ_CTL_CMP];
  assign buf_rd_o = exec && byte_tick && sel_mode && val[`DSQ_VAL_BUF]
                    && (!rd_dir || ctl[`DSQ_CTL_CMP]);
  assign buf_wr_data_o = rx_byte_i;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_gate_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (r_r.st == SEQ_FETCH && store_pc_q[`DSQ_INS_CTL_LSB + `DSQ_CTL_WG]
     && !store_pc_q[`DSQ_INS_CTL_LSB + `DSQ_CTL_CNT_SEL] && !bus_wr) |=> write_gate_o)
    else $error("write gate not driven by instruction");

  chk_mark_window: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    mark_enable_output_o |-> ctl[`DSQ_CTL_MARK] && r_r.mark[bit_num])
    else $error("mark output outside pattern bits");

  chk_ptr_advance: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_wr && idx >= `DSQ_IDX_ERR && idx <= `DSQ_IDX_CNT)
    |=> r_r.ptr == $past(r_r.ptr) + 5'h01)
    else $error("window write did not advance pointer");

  chk_branch_first: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ins_done && ctl[`DSQ_CTL_BRANCH] && !bus_wr) |=> r_r.pc == $past(r_r.branch))
    else $error("branch target not taken");

  chk_repeat_jump: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (ins_done && !ctl[`DSQ_CTL_BRANCH] && ctl[`DSQ_CTL_REPEAT])
    |=> r_r.pc == ($past(r_r.sector) != 8'h00 ? $past(r_r.repeat_tgt) : $past(r_r.pc) + 5'h01))
    else $error("repeat jump address wrong");

  chk_sector_dec: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (xfer && !r_r.xfer_d && r_r.sector != 8'h00 && !bus_wr)
    |=> r_r.sector == $past(r_r.sector) - 8'h01 ##1 !(xfer && !r_r.xfer_d))
    else $error("sector counter not decremented once");

  chk_stop_now: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (r_r.st == SEQ_WAIT && cnt[`DSQ_CNT_STOP])
    |=> r_r.st == SEQ_IDLE && r_r.stopped && !write_gate_o && !read_gate_o)
    else $error("stop did not drop outputs");

  chk_count_len: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (r_r.st == SEQ_FETCH && !store_pc_q[`DSQ_INS_CTL_LSB + `DSQ_CTL_CNT_SEL] && !bus_wr)
    |=> exec && r_r.bytes == $past(store_pc_q[7:0]))
    else $error("byte counter not loaded with count");

  chk_retry_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    r_r.rty_s[2] |-> !read_gate_o)
    else $error("read gate open during retry");

  chk_bus_answer: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("bus request not answered in one wait cycle");
endmodule // disk_seq

// File: verif/disk_drive_model.sv
`timescale 1ns/100ps
module disk_drive_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // Bench control
  input  wire logic       index_req_i,
  input  wire logic       sector_req_i,
  input  wire logic       retry_req_i,
  // Drive pins
  output logic            index_o,
  output logic            sector_mark_o,
  output logic            retry_o,
  // Serial channel and buffer
  output logic      [7:0] rx_byte_o,
  output logic            checksum_bit_o,
  output logic      [7:0] buf_rd_data_o
);
  logic [7:0] pat_r;
  logic [2:0] ix_r;
  logic [2:0] sm_r;

  // Data lines change every clock so a late sample cannot pass unseen
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pat_r <= 8'h00;
      ix_r  <= 3'h0;
      sm_r  <= 3'h0;
    end else begin
      pat_r <= pat_r + 8'h1D;
      ix_r  <= index_req_i ? 3'h7 : ix_r - {2'h0, |ix_r};
      sm_r  <= sector_req_i ? 3'h7 : sm_r - {2'h0, |sm_r};
    end
  end

  // Index held several clocks to get through the input synchroniser
  assign index_o        = |ix_r;
  assign sector_mark_o  = |sm_r;
  assign retry_o        = retry_req_i;
  assign rx_byte_o      = pat_r;
  assign checksum_bit_o = pat_r[0];
  assign buf_rd_data_o  = ~pat_r;
endmodule // disk_drive_model

// File: verif/disk_sequencer_instruction_fields_tb.sv
`include "dsq_params.svh"
`timescale 1ns/100ps
module disk_sequencer_instruction_fields_tb;
  localparam int BD = 2;
  localparam int BT = 8 * BD;
  localparam logic [7:0] B  = 8'(BT);
  localparam logic [7:0] B2 = 8'(2 * BT);
  localparam logic [7:0] M  = 8'(2 * BD);

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic        wrq;
  logic        ixreq = 1'b0;
  logic        smreq = 1'b0;
  logic        rtyreq = 1'b0;
  logic        swd, ecc, crc;
  logic [7:0]  bwd;
  logic [31:0] wsh = 32'h0;
  logic [1:0]  sel_seen = 2'b00;
  logic [7:0]  bw_err = 8'h00;
  logic        ix, sm, rty, cks;
  logic [7:0]  rx, bdat;
  logic        wg, rg, mk, cmp, chkf, last, brd, bwr;
  logic [7:0]  obs;
  integer      cnt [8];
  integer      snap [8];
  integer      mismatches = 0;
  integer      checked = 0;

  always #10 clk = ~clk;

  disk_seq #(.BIT_DIV(BD)) DUT (
    .ref_clk_i(clk), .rst_b_i(rst_b),
    .avs_address_i(adr), .avs_read_i(av_rd), .avs_write_i(av_wr),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq),
    .index_i(ix), .sector_mark_i(sm), .retry_i(rty),
    .write_gate_o(wg), .read_gate_o(rg), .mark_enable_output_o(mk),
    .serial_write_data_o(swd), .rx_byte_i(rx), .checksum_bit_i(cks),
    .compare_enable_o(cmp), .checksum_field_o(chkf), .ecc_select_o(ecc),
    .crc_select_o(crc), .last_segment_o(last), .buf_rd_data_i(bdat),
    .buf_rd_o(brd), .buf_wr_o(bwr), .buf_wr_data_o(bwd)
  );

  disk_drive_model drive (
    .ref_clk_i(clk), .rst_b_i(rst_b), .index_req_i(ixreq),
    .sector_req_i(smreq), .retry_req_i(rtyreq),
    .index_o(ix), .sector_mark_o(sm), .retry_o(rty),
    .rx_byte_o(rx), .checksum_bit_o(cks), .buf_rd_data_o(bdat)
  );

  // Cycles each observed output spends high; X propagates into the count
  assign obs = {brd, bwr, last, chkf, cmp, mk, rg, wg};
  initial for (int k = 0; k < 8; k++) cnt[k] = 0;
  always @(posedge clk) for (int k = 0; k < 8; k++) cnt[k] <= cnt[k] + obs[k];

  // Serial stream, checksum select and buffer data seen by the far side
  always @(posedge clk) begin
    if (wg) wsh <= {wsh[30:0], swd};
    if (chkf) sel_seen <= {ecc, crc};
    if (bwr) bw_err <= bw_err | (bwd ^ rx);
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d,
                     output logic [31:0] q);
    adr <= {i, 2'b00};
    av_rd <= !w;
    av_wr <= w;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wrq !== 1'b0);
    q = rdat;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic w(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask

  task automatic r(input logic [5:0] i, output logic [31:0] q);
    bus(1'b0, i, 32'h0, q);
  endtask

  // Pointer rewritten before each window, since every window write moves it
  task automatic ld(input logic [4:0] a, input logic [7:0] e, c, v, n);
    logic [31:0] q;
    logic [7:0]  f [4];
    f = '{e, c, v, n};
    for (int k = 0; k < 4; k++) begin
      w(`DSQ_IDX_START, {27'h0, a});
      w(6'(`DSQ_IDX_ERR + k), {24'h0, f[k]});
    end
    r(`DSQ_IDX_START, q);
    chk(q, {27'h0, a + 5'h01});
  endtask

  task automatic go(input logic [4:0] a);
    snap = cnt;
    w(`DSQ_IDX_START, {27'h0, a});
    w(`DSQ_IDX_CMD, 32'h1);
  endtask

  // Only the watchdog ends a sequencer that never goes idle
  task automatic idle_wait;
    logic [31:0] q;
    do begin
      r(`DSQ_IDX_STATUS, q);
    end while (q[10:9] !== 2'b00);
  endtask

  task automatic fin(input logic [63:0] e);
    idle_wait;
    for (int k = 0; k < 8; k++) chk(cnt[k] - snap[k], {24'h0, e[8*k +: 8]});
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_fields;
    logic [31:0] q;
    ld(5'd0, 8'h0, 8'h2C, 8'hA5, 8'h01);
    ld(5'd1, 8'h2, 8'h90, 8'hA8, 8'h01);
    ld(5'd2, 8'h0, 8'h40, 8'h00, 8'h01);
    w(`DSQ_IDX_START, 32'h0);
    r(`DSQ_IDX_CTL, q);
    chk(q, 32'h2C);
    r(6'h3F, q);
    chk(q, 32'h0);
    w(`DSQ_IDX_MARK, 32'h01);
    w(`DSQ_IDX_SECTOR, 32'h03);
    go(5'd0);
    fin({8'h00, 8'h02, B2, B2, B2, M, B2, B2});
    chk(wsh, 32'hCC33_CC33);
    chk({30'h0, sel_seen}, 32'h2);
    r(`DSQ_IDX_SECTOR, q);
    chk(q, 32'h02);
    r(`DSQ_IDX_STATUS, q);
    chk(q & 32'h80, 32'h80);
  endtask

  task automatic t_branch;
    ld(5'd8, 8'h0, 8'h23, 8'h00, 8'h00);
    ld(5'd16, 8'h0, 8'h10, 8'h00, 8'h00);
    ld(5'd17, 8'h0, 8'h40, 8'h00, 8'h01);
    ld(5'd20, 8'h0, 8'h20, 8'h00, 8'h00);
    ld(5'd21, 8'h0, 8'h40, 8'h00, 8'h01);
    w(`DSQ_IDX_BRANCH, 32'd16);
    w(`DSQ_IDX_REPEAT, 32'd20);
    w(`DSQ_IDX_SECTOR, 32'h05);
    go(5'd8);
    fin({48'h0, B, B});
  endtask

  task automatic t_repeat;
    ld(5'd12, 8'h0, 8'h21, 8'h00, 8'h00);
    ld(5'd13, 8'h0, 8'h40, 8'h00, 8'h01);
    go(5'd12);
    fin({56'h0, B2});
    w(`DSQ_IDX_SECTOR, 32'h00);
    go(5'd12);
    fin({56'h0, B});
  endtask

  task automatic t_wait;
    logic [31:0] q;
    ld(5'd24, 8'h0, 8'h40, 8'h00, 8'h20);
    ld(5'd25, 8'h0, 8'h10, 8'h00, 8'h00);
    ld(5'd26, 8'h0, 8'h40, 8'h00, 8'h01);
    go(5'd24);
    repeat (40) @(posedge clk);
    chk(cnt[0] - snap[0] + cnt[1] - snap[1], 32'h0);
    ixreq <= 1'b1;
    @(posedge clk);
    ixreq <= 1'b0;
    fin({48'h0, B, 8'h00});
    // Sector wait must ignore index; retry held keeps the read gate shut
    ld(5'd24, 8'h0, 8'h40, 8'h00, 8'h10);
    rtyreq <= 1'b1;
    go(5'd24);
    ixreq <= 1'b1;
    @(posedge clk);
    ixreq <= 1'b0;
    repeat (40) @(posedge clk);
    r(`DSQ_IDX_STATUS, q);
    chk(q & 32'h11F, 32'h118);
    smreq <= 1'b1;
    @(posedge clk);
    smreq <= 1'b0;
    fin(64'h0);
    rtyreq <= 1'b0;
  endtask

  task automatic t_chain;
    logic [31:0] q;
    ld(5'd28, 8'h2, 8'h80, 8'h80, 8'hFF);
    ld(5'd29, 8'h2, 8'h80, 8'hA0, 8'hFF);
    ld(5'd30, 8'h0, 8'h40, 8'h00, 8'h01);
    w(`DSQ_IDX_SECTOR, 32'h02);
    go(5'd28);
    idle_wait;
    chk(cnt[6] - snap[6], 32'd512);
    chk(cnt[5] - snap[5], 32'(256 * BT));
    chk({24'h0, bw_err}, 32'h0);
    r(`DSQ_IDX_SECTOR, q);
    chk(q, 32'h01);
    ld(5'd5, 8'h2, 8'h80, 8'h40, 8'h00);
    ld(5'd6, 8'h0, 8'h40, 8'h00, 8'h01);
    go(5'd5);
    fin(64'h0);
    r(`DSQ_IDX_SECTOR, q);
    chk(q, 32'h00);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_fields;
    t_branch;
    t_repeat;
    t_wait;
    t_chain;
    end_of_test;
  end

  // Chained 256-byte fields take about 8200 clocks; the rest a few hundred each
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_of_test;
  end
endmodule // disk_sequencer_instruction_fields_tb
